/* verilog/eab_map.svh */
// register map, field positions, reset values and sizes of the embedded array block
`ifndef EAB_MAP_SVH
`define EAB_MAP_SVH
// ==========================================================
// register byte offsets
`define EAB_CTRL_OFS  12'h000
`define EAB_STAT_OFS  12'h004
`define EAB_MC_BASE   12'h040
`define EAB_PT_BASE   12'h400
// ==========================================================
// reset values
`define EAB_CTRL_RST  12'h000
`define EAB_MC_RST    9'h000
// ==========================================================
// control register fields
`define EAB_C_MODE    0
`define EAB_C_SHAPE   1
`define EAB_C_IOCLK   4
`define EAB_C_PIPE    5
`define EAB_C_PGEN    6
`define EAB_C_PGSEL   7
`define EAB_C_CLK1F   9
`define EAB_C_CLRINV  10
// ==========================================================
// macrocell configuration fields
`define EAB_M_RT      0
`define EAB_M_BYP     2
`define EAB_M_CSEL    3
`define EAB_M_CLRS    4
`define EAB_M_INV     6
`define EAB_M_XPOL    7
`define EAB_M_DON     8
// ==========================================================
// sizes
`define EAB_NMC       16
`define EAB_NPT       32
`define EAB_NIN       32
`define EAB_NFB       9
`define EAB_NLIT      41
`define EAB_MBITS     2048
`define EAB_AW        11
`endif

/* verilog/eab_pkg.sv */
// types shared by the embedded array block modules
package eab_pkg;
  typedef enum logic [1:0] {
    EAB_RT_D  = 2'b00,
    EAB_RT_T  = 2'b01,
    EAB_RT_JK = 2'b10,
    EAB_RT_SR = 2'b11
  } eab_rtype_t;
  typedef enum logic [1:0] {
    EAB_CLR_NONE = 2'b00,
    EAB_CLR_0    = 2'b01,
    EAB_CLR_1    = 2'b10,
    EAB_CLR_RSV  = 2'b11
  } eab_clrsel_t;
endpackage

/* verilog/eab_macrocell.sv */
// one product-term macrocell with programmable register
`include "eab_map.svh"
module eab_macrocell (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // product-term inputs and masks
  input  wire logic [`EAB_NLIT-1:0]  lit,
  input  wire logic [`EAB_NLIT-1:0]  ptt0,
  input  wire logic [`EAB_NLIT-1:0]  ptc0,
  input  wire logic [`EAB_NLIT-1:0]  ptt1,
  input  wire logic [`EAB_NLIT-1:0]  ptc1,
  input  wire logic [8:0]            cfg,
  // register control
  input  wire logic [1:0]            ce,
  input  wire logic [1:0]            clr,
  input  wire logic                  chip_clr_n,
  // expanders and result
  input  wire logic                  exp_in,
  output logic                       exp_out,
  output logic                       mc_out
);
  typedef struct packed {
    logic r;
  } eab_mc_st_t;
  eab_mc_st_t q;
  eab_mc_st_t d;
  logic pt0;
  logic pt1;
  logic sum;
  logic f;
  logic nx;
  logic cl;

  assign pt0 = &(~ptt0 | lit) & &(~ptc0 | ~lit);
  assign pt1 = (&(~ptt1 | lit) & &(~ptc1 | ~lit)) ^ cfg[`EAB_M_INV];
  assign sum = pt0 | pt1 | exp_in;
  assign exp_out = cfg[`EAB_M_DON] ? sum : 1'b0;
  assign f = sum ^ cfg[`EAB_M_XPOL];
  assign mc_out = cfg[`EAB_M_BYP] ? f : q.r;

  always_comb
  begin
    case (eab_pkg::eab_rtype_t'(cfg[`EAB_M_RT+:2]))
      eab_pkg::EAB_RT_D:  nx = f;
      eab_pkg::EAB_RT_T:  nx = q.r ^ f;
      eab_pkg::EAB_RT_JK: nx = (pt0 & ~q.r) | (~pt1 & q.r);
      eab_pkg::EAB_RT_SR: nx = pt0 | (~pt1 & q.r);
      default:            nx = f;
    endcase
    case (eab_pkg::eab_clrsel_t'(cfg[`EAB_M_CLRS+:2]))
      eab_pkg::EAB_CLR_0: cl = clr[0];
      eab_pkg::EAB_CLR_1: cl = clr[1];
      default:            cl = 1'b0;
    endcase
    d = q;
    if (ce[cfg[`EAB_M_CSEL]])
      d.r = nx;
    if (cl)
      d.r = 1'b0;
    if (!chip_clr_n)
      d.r = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end
endmodule // eab_macrocell

/* verilog/eab_mem.sv */
// 2048-bit synchronous array with selectable word shape
`include "eab_map.svh"
module eab_mem (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // write side
  input  wire logic                wr,
  input  wire logic [`EAB_AW-1:0]  wa,
  input  wire logic [15:0]         wd,
  input  wire logic [2:0]          shape,
  // read side
  input  wire logic [`EAB_AW-1:0]  ra,
  output logic [15:0]              rd
);
  typedef struct packed {
    logic [`EAB_MBITS-1:0] bits;
  } eab_mem_st_t;
  eab_mem_st_t q;
  eab_mem_st_t d;
  logic [2:0]         sh;
  logic [4:0]         wid;
  logic [`EAB_AW-1:0] am;
  logic [`EAB_AW-1:0] wb;
  logic [`EAB_AW-1:0] rb;

  // shapes above the last one fall back to one bit wide
  assign sh  = (shape > 3'h4) ? 3'h4 : shape;
  assign wid = 5'(5'h10 >> sh);
  assign am  = ~(11'h7FF << (4'h7 + 4'(sh)));
  assign wb  = 11'((wa & am) << (3'h4 - sh));
  assign rb  = 11'((ra & am) << (3'h4 - sh));

  always_comb
  begin
    d = q;
    rd = 16'h0000;
    for (int b = 0; b < 16; b++)
    begin
      if (b < int'(wid))
      begin
        // old contents are read while a write to the same word is pending
        rd[b] = q.bits[11'(rb + 11'(b))];
        if (wr)
          d.bits[11'(wb + 11'(b))] = wd[b];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end
endmodule // eab_mem

/* verilog/eab_top.sv */
// embedded array block: macrocell or memory mode, configured over ahb-lite
`include "eab_map.svh"
module eab_top (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // block controls
  input  wire logic                 chip_wide_clear_n,
  input  wire logic [1:0]           blk_clk,
  input  wire logic [1:0]           blk_ena,
  input  wire logic [1:0]           aclr_in,
  // product-term inputs
  input  wire logic [`EAB_NIN-1:0]  din,
  // memory ports
  input  wire logic [15:0]          wdata,
  input  wire logic [12:0]          waddr,
  input  wire logic                 we,
  input  wire logic [12:0]          raddr,
  input  wire logic                 re,
  // outputs
  output logic [15:0]               blk_out,
  output logic [9:0]                local_out,
  output logic [15:0]               col_out,
  output logic                      col_oe
);
  typedef struct packed {
    logic                          rdy;
    logic                          resp;
    logic [11:0]                   ctrl;
    logic [`EAB_NMC-1:0][8:0]      mc;
    logic [`EAB_NPT-1:0][40:0]     ptt;
    logic [`EAB_NPT-1:0][40:0]     ptc;
    logic                          ap_v;
    logic [11:0]                   ap_a;
    logic [31:0]                   rdat;
    logic [1:0]                    ck;
    logic [15:0]                   wd;
    logic [`EAB_AW-1:0]            wa;
    logic                          we;
    logic                          wstb;
    logic [`EAB_AW-1:0]            ra;
    logic [1:0]                    rpg;
    logic [15:0]                   dq;
    logic [15:0]                   bo;
    logic [15:0]                   col;
    logic                          coe;
  } eab_top_st_t;

  eab_top_st_t q;
  eab_top_st_t d;
  logic [`EAB_NLIT-1:0] lit;
  logic [`EAB_NMC-1:0]  mco;
  logic [`EAB_NMC-1:0]  xo;
  logic [`EAB_NMC-1:0]  xi;
  logic [1:0]           ev;
  logic [1:0]           ce;
  logic [1:0]           clr;
  logic [15:0]          rdat;
  logic [15:0]          mw;
  logic                 mode;
  logic                 ioclk;
  logic                 wev;
  logic                 aev;
  logic                 dev;

  // ==========================================================
  // register read decode
  function automatic logic [31:0] rd_word(input logic [31:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[31:12] == 20'h00000)
    begin
      if (a[11:0] == `EAB_CTRL_OFS)
        v = {20'h00000, q.ctrl};
      else if (a[11:0] == `EAB_STAT_OFS)
        v = {13'h0000, mode, q.coe, q.wstb, q.bo};
      else if (a[11:6] == `EAB_MC_BASE >> 6)
        v = {23'h000000, q.mc[a[5:2]]};
      else if (a[11:9] == `EAB_PT_BASE >> 9)
      begin
        case (a[3:2])
          2'h0:    v = q.ptt[a[8:4]][31:0];
          2'h1:    v = {23'h000000, q.ptt[a[8:4]][40:32]};
          2'h2:    v = q.ptc[a[8:4]][31:0];
          default: v = {23'h000000, q.ptc[a[8:4]][40:32]};
        endcase
      end
    end
    return v;
  endfunction

  function automatic logic pg_ok(input logic [1:0] p, input logic [11:0] c);
    return ~c[`EAB_C_PGEN] | (p == c[`EAB_C_PGSEL+:2]);
  endfunction

  // ==========================================================
  // block clocks, enables and clears
  assign mode  = q.ctrl[`EAB_C_MODE];
  assign ioclk = q.ctrl[`EAB_C_IOCLK];
  assign ev[0] = blk_clk[0] & ~q.ck[0];
  // the second block clock can carry the falling edge of the first
  assign ev[1] = q.ctrl[`EAB_C_CLK1F] ? (~blk_clk[0] & q.ck[0])
                                      : (blk_clk[1] & ~q.ck[1]);
  assign ce    = ev & blk_ena;
  assign clr   = aclr_in ^ q.ctrl[`EAB_C_CLRINV+:2];
  assign wev   = ce[0];
  assign aev   = ioclk ? ce[0] : ce[1];
  assign dev   = ce[1];

  // ==========================================================
  // product-term literals and macrocells
  assign lit = {q.bo[`EAB_NFB-1:0], din};

  generate
    for (genvar i = 0; i < `EAB_NMC; i++)
    begin : g_mc
      if (i == `EAB_NMC - 1)
      begin : g_end
        assign xi[i] = 1'b0;
      end
      else
      begin : g_chain
        assign xi[i] = xo[i+1];
      end
      eab_macrocell u_mc (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .lit        (lit),
        .ptt0       (q.ptt[2*i]),
        .ptc0       (q.ptc[2*i]),
        .ptt1       (q.ptt[2*i+1]),
        .ptc1       (q.ptc[2*i+1]),
        .cfg        (q.mc[i]),
        .ce         (ce),
        .clr        (clr),
        .chip_clr_n (chip_wide_clear_n),
        .exp_in     (xi[i]),
        .exp_out    (xo[i]),
        .mc_out     (mco[i])
      );
    end
  endgenerate

  // ==========================================================
  // memory array
  eab_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr      (q.wstb),
    .wa      (q.wa),
    .wd      (q.wd),
    .shape   (q.ctrl[`EAB_C_SHAPE+:3]),
    .ra      (q.ra),
    .rd      (rdat)
  );

  assign mw = q.ctrl[`EAB_C_PIPE] ? q.dq : rdat;

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    d.rdy = 1'b1;
    d.resp = 1'b0;
    d.ck = blk_clk;
    // bus address phase, word writes only
    d.ap_v = hsel & hready & htrans[1] & hwrite & (hsize == 3'h2)
             & (haddr[31:12] == 20'h00000);
    d.ap_a = haddr[11:0];
    d.rdat = 32'h0000_0000;
    if (hsel & hready & htrans[1] & ~hwrite)
      d.rdat = rd_word(haddr);
    // bus data phase
    if (q.ap_v)
    begin
      if (q.ap_a == `EAB_CTRL_OFS)
        d.ctrl = hwdata[11:0];
      else if (q.ap_a[11:6] == `EAB_MC_BASE >> 6)
        d.mc[q.ap_a[5:2]] = hwdata[8:0];
      else if (q.ap_a[11:9] == `EAB_PT_BASE >> 9)
      begin
        case (q.ap_a[3:2])
          2'h0:    d.ptt[q.ap_a[8:4]][31:0] = hwdata;
          2'h1:    d.ptt[q.ap_a[8:4]][40:32] = hwdata[8:0];
          2'h2:    d.ptc[q.ap_a[8:4]][31:0] = hwdata;
          default: d.ptc[q.ap_a[8:4]][40:32] = hwdata[8:0];
        endcase
      end
    end
    // memory write side: inputs and strobe caught together, array written one cycle later
    d.wstb = 1'b0;
    if (wev)
    begin
      d.wd = wdata;
      d.wa = waddr[`EAB_AW-1:0];
      d.we = we;
      // only the block owning the page writes
      d.wstb = mode & we & pg_ok(waddr[12:11], q.ctrl);
    end
    // read address register, loaded while read is enabled
    if (aev & re)
    begin
      d.ra = raddr[`EAB_AW-1:0];
      d.rpg = raddr[12:11];
    end
    if (dev)
      d.dq = rdat;
    // side clears
    if (clr[0])
    begin
      d.wd = 16'h0000;
      d.wa = 11'h000;
      d.we = 1'b0;
      d.wstb = 1'b0;
      if (ioclk)
      begin
        d.ra = 11'h000;
        d.rpg = 2'h0;
      end
    end
    if (clr[1])
    begin
      d.dq = 16'h0000;
      if (!ioclk)
      begin
        d.ra = 11'h000;
        d.rpg = 2'h0;
      end
    end
    // outputs
    d.bo = mode ? mw : mco;
    d.col = mw;
    d.coe = mode & pg_ok(q.rpg, q.ctrl);
    // chip-wide clear wins over every other control
    if (!chip_wide_clear_n)
    begin
      d.wd = 16'h0000;
      d.wa = 11'h000;
      d.we = 1'b0;
      d.wstb = 1'b0;
      d.ra = 11'h000;
      d.rpg = 2'h0;
      d.dq = 16'h0000;
      d.bo = 16'h0000;
      d.col = 16'h0000;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.rdy <= 1'b1;
      q.ctrl <= `EAB_CTRL_RST;
    end
    else
      q <= d;
  end

  // ==========================================================
  // outputs
  assign hreadyout = q.rdy;
  assign hrdata    = q.rdat;
  assign hresp     = q.resp;
  assign blk_out   = q.bo;
  // the tenth local line repeats the ninth
  assign local_out = {q.bo[8], q.bo[8:0]};
  assign col_out   = q.col;
  assign col_oe    = q.coe;
endmodule // eab_top

/* dv/eab_top_chk.sv */
// concurrent checks on the ports of the embedded array block
module eab_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // block
  input wire logic        chip_wide_clear_n,
  input wire logic [15:0] blk_out,
  input wire logic [9:0]  local_out,
  input wire logic [15:0] col_out,
  input wire logic        col_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_ph;
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;
  // ==========================================================
  // bus answers
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rdzero; !rd_ph |=> hrdata == 32'h0; endproperty
  a_rdzero: assert property (p_rdzero) else $error("hrdata not zero outside read");
  property p_unmapped; rd_ph && haddr == 32'h8 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_stat_blk; rd_ph && haddr == 32'h4 |=> hrdata[15:0] == $past(blk_out); endproperty
  a_stat_blk: assert property (p_stat_blk) else $error("status block output mismatch");
  property p_stat_oe; rd_ph && haddr == 32'h4 |=> hrdata[17] == $past(col_oe); endproperty
  a_stat_oe: assert property (p_stat_oe) else $error("status drive enable mismatch");
  // ==========================================================
  // block outputs
  property p_local; local_out == {blk_out[8], blk_out[8:0]}; endproperty
  a_local: assert property (p_local) else $error("local outputs mismatch");
  property p_clr_col; !chip_wide_clear_n |=> col_out == 16'h0; endproperty
  a_clr_col: assert property (p_clr_col) else $error("column data not cleared");
  property p_clr_blk; !chip_wide_clear_n |=> blk_out == 16'h0; endproperty
  a_clr_blk: assert property (p_clr_blk) else $error("block output not cleared");
endmodule // eab_chk

bind eab_top eab_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .chip_wide_clear_n(chip_wide_clear_n),
  .blk_out(blk_out), .local_out(local_out), .col_out(col_out), .col_oe(col_oe));

/* dv/eab_cells.sv */
// neighbouring logic cells that make the block clocks and enables
module eab_cells (
  // clock
  input wire logic   hclk,
  // block clocks
  output logic [1:0] blk_clk,
  output logic [1:0] blk_ena
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    blk_clk = 2'b00;
    blk_ena = 2'b00;
  end
  // one clock pulse; the clock stands low between pulses
  task pulse(input int k, input logic ena);
    begin
      @(posedge hclk);
      blk_clk[k] <= 1'b1;
      blk_ena[k] <= ena;
      repeat (2) @(posedge hclk);
      blk_clk[k] <= 1'b0;
      blk_ena[k] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule // eab_cells

/* dv/eab_top_test.sv */
// self-checking bench of the embedded array block
module eab_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, din;
  logic [1:0]  htrans, blk_clk, blk_ena, aclr;
  logic [2:0]  hsize;
  logic        chip_wide_clear_n, we, re, col_oe;
  logic [15:0] wdata, blk_out, col_out;
  logic [12:0] waddr, raddr;
  logic [9:0]  local_out;
  int          err_count, n_checks;
  assign hready = hreadyout;
  eab_cells cells_u (.hclk(hclk), .blk_clk(blk_clk), .blk_ena(blk_ena));
  eab_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .chip_wide_clear_n(chip_wide_clear_n), .blk_clk(blk_clk),
    .blk_ena(blk_ena), .aclr_in(aclr), .din(din), .wdata(wdata), .waddr(waddr), .we(we),
    .raddr(raddr), .re(re), .blk_out(blk_out), .local_out(local_out), .col_out(col_out),
    .col_oe(col_oe));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ==========================================================
  // shared tasks
  task wrap_up;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_checks++;
      if (g !== e)
      begin
        err_count++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wait_rdy;
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge hclk);
        n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
        err_count++;
        $display("[FAIL] bus ready expected 1 seen timeout");
        wrap_up;
      end
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    begin
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'b010;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    begin
      ahb(1'b1, a, d, x);
    end
  endtask
  task rd_cmp(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    begin
      ahb(1'b0, a, 32'h0, x);
      cmp(nm, e, x);
    end
  endtask
  // ==========================================================
  // scenarios
  task s_regs;
    begin
      rd_cmp("ctrl reset", 32'h000, 32'h000);
      rd_cmp("unmapped", 32'h008, 32'h000);
      wr(32'h044, 32'h1FF);
      rd_cmp("mc1 cfg", 32'h044, 32'h1FF);
      wr(32'h044, 32'h000);
    end
  endtask
  task s_macro;
    begin
      wr(32'h400, 32'h1);
      wr(32'h410, 32'h1);
      wr(32'h418, 32'h1);
      din <= 32'h1;
      cells_u.pulse(0, 1'b1);
      cmp("mc0 load", 32'h1, {31'h0, blk_out[0]});
      din <= 32'h0;
      cells_u.pulse(0, 1'b0);
      cmp("mc0 no enable", 32'h1, {31'h0, blk_out[0]});
      cells_u.pulse(0, 1'b1);
      cmp("mc0 reload", 32'h0, {31'h0, blk_out[0]});
      wr(32'h040, 32'h004);
      din <= 32'h1;
      repeat (3) @(posedge hclk);
      cmp("mc0 bypass", 32'h1, {31'h0, blk_out[0]});
      wr(32'h040, 32'h000);
    end
  endtask
  task s_mem;
    begin
      wr(32'h000, 32'h001);
      waddr <= 13'h0005;
      wdata <= 16'hA5C3;
      we    <= 1'b1;
      raddr <= 13'h0005;
      re    <= 1'b1;
      cells_u.pulse(0, 1'b1);
      wdata <= 16'h5A5A;
      cells_u.pulse(1, 1'b1);
      cmp("mem read", 32'hA5C3, {16'h0, blk_out});
      cmp("mem oe", 32'h1, {31'h0, col_oe});
      rd_cmp("status", 32'h004, 32'h0006A5C3);
      cells_u.pulse(0, 1'b0);
      cells_u.pulse(1, 1'b1);
      cmp("write no enable", 32'hA5C3, {16'h0, blk_out});
      we <= 1'b0;
    end
  endtask
  task s_shape;
    begin
      wr(32'h000, 32'h009);
      waddr <= 13'h0007;
      wdata <= 16'hFFFF;
      we    <= 1'b1;
      raddr <= 13'h0007;
      cells_u.pulse(0, 1'b1);
      we <= 1'b0;
      cells_u.pulse(1, 1'b1);
      cmp("2048x1 word", 32'h1, {16'h0, blk_out});
    end
  endtask
  task s_page;
    begin
      wr(32'h000, 32'h0C1);
      rd_cmp("ctrl page", 32'h000, 32'h0C1);
      raddr <= 13'h1005;
      cells_u.pulse(1, 1'b1);
      cmp("other page oe", 32'h0, {31'h0, col_oe});
      raddr <= 13'h0805;
      cells_u.pulse(1, 1'b1);
      cmp("own page oe", 32'h1, {31'h0, col_oe});
    end
  endtask
  task s_clear;
    begin
      chip_wide_clear_n <= 1'b0;
      repeat (2) @(posedge hclk);
      chip_wide_clear_n <= 1'b1;
      cmp("clear blk_out", 32'h0, {16'h0, blk_out});
      cmp("clear col_out", 32'h0, {16'h0, col_out});
    end
  endtask
  task s_modes;
    begin
      // input/output scheme with pipelined output
      wr(32'h000, 32'h031);
      raddr <= 13'h0005;
      re    <= 1'b1;
      cells_u.pulse(0, 1'b1);
      cmp("pipe held", 32'h0, {16'h0, blk_out});
      raddr <= 13'h0000;
      cells_u.pulse(1, 1'b1);
      cmp("pipe output", 32'hA5C3, {16'h0, blk_out});
      aclr <= 2'b10;
      repeat (3) @(posedge hclk);
      aclr <= 2'b00;
      cmp("output side clear", 32'h0, {16'h0, blk_out});
      // toggle register with selectable clear
      wr(32'h000, 32'h000);
      wr(32'h040, 32'h011);
      aclr <= 2'b01;
      repeat (3) @(posedge hclk);
      aclr <= 2'b00;
      cmp("mc0 clear", 32'h0, {31'h0, blk_out[0]});
      din <= 32'h1;
      cells_u.pulse(0, 1'b1);
      cmp("mc0 toggle on", 32'h1, {31'h0, blk_out[0]});
      cells_u.pulse(0, 1'b1);
      cmp("mc0 toggle off", 32'h0, {31'h0, blk_out[0]});
      // terms borrowed from the neighbour
      wr(32'h040, 32'h004);
      din <= 32'h0;
      wr(32'h044, 32'h100);
      repeat (3) @(posedge hclk);
      cmp("expander", 32'h1, {31'h0, blk_out[0]});
    end
  endtask
  initial
  begin
    err_count = 0;
    n_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    chip_wide_clear_n = 1'b1;
    aclr = 2'b00;
    din = 32'h0;
    wdata = 16'h0;
    waddr = 13'h0;
    we = 1'b0;
    raddr = 13'h0;
    re = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs;
    s_macro;
    s_mem;
    s_shape;
    s_page;
    s_clear;
    s_modes;
    wrap_up;
  end
endmodule // eab_top_test
